// *** hw/can_event_fifo_interface.sv ***
// CAN event queue block: transmit queue, receive event queue, lost
// counter, timestamp and event filter behind an APB slave.
// Assumes APB on pclk; event and firmware ports synchronous to pclk.
`timescale 1ns/1ps
module can_event_fifo_interface #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Event source from the CAN controllers
  input  wire logic        ev_valid,
  input  wire logic [1:0]  ev_port,
  input  wire logic [28:0] ev_id,
  input  wire logic [4:0]  ev_type,
  input  wire logic [3:0]  ev_len,
  input  wire logic [63:0] ev_data,
  input  wire logic [2:0]  bus_state_in,
  // Firmware side of the outbound queue
  input  wire logic        fw_take,
  output logic             fw_avail,
  output logic      [1:0]  fw_port,
  output logic      [28:0] fw_id,
  output logic             fw_ext,
  output logic             fw_remote,
  output logic      [3:0]  fw_len,
  output logic      [63:0] fw_data
);

  localparam int TXW = 2 + 29 + 1 + 1 + 4 + 64;
  localparam int EW  = evq_pkg::ENTRY_W;

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [TXW-1:0] tx_mem [DEPTH];
  logic [EW-1:0]  rx_mem [DEPTH];
  logic [AW-1:0]  tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [8:0]     tx_lvl_reg, rx_lvl_reg;
  logic [31:0]    lost_reg;
  logic [31:0]    ts_reg;
  logic [7:0]     tick_reg;
  logic [2:0]     bus_state_reg;
  logic [63:0]    txd_reg;
  logic [31:0]    txh_reg;
  logic [EW-1:0]  rx_win_reg;
  logic [31:0]    flt_cfg_reg;
  logic [28:0]    flt_id0_reg, flt_id1_reg;
  logic [7:0]     flt_cnt_reg;
  logic [4:0]     flt_type_reg;
  logic [28:0]    flt_idm_reg;

  logic wr_en, rd_en;
  logic tx_push, tx_pop, rx_push, rx_pop, tx_clr, rx_clr;
  logic bus_change;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // Clear commands act on value 1 only
  assign tx_clr  = wr_en && (paddr == evq_pkg::OFS_CTRL) && pwdata[0];
  assign rx_clr  = wr_en && (paddr == evq_pkg::OFS_CTRL) && pwdata[1];
  // Full queue drops the new message
  assign tx_push = wr_en && (paddr == evq_pkg::OFS_TX_PUSH)
                   && (tx_lvl_reg < 9'(evq_pkg::QUEUE_MAX)) && !tx_clr;
  assign tx_pop  = fw_avail && fw_take && !tx_clr;
  assign bus_change = bus_state_in != bus_state_reg;
  assign rx_push = ev_valid && (rx_lvl_reg < 9'(evq_pkg::QUEUE_MAX)) && !rx_clr;
  assign rx_pop  = wr_en && (paddr == evq_pkg::OFS_RX_POP) && (rx_lvl_reg != 9'h000);

  // ----------------------------------------------------------------
  // Microsecond timestamp counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 8'h00;
      ts_reg   <= 32'h0000_0000;
    end else if (tick_reg == 8'(evq_pkg::TS_TICK_CYC - 1)) begin
      tick_reg <= 8'h00;
      ts_reg   <= ts_reg + 32'h0000_0001;
    end else begin
      tick_reg <= tick_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Outbound queue
  // ----------------------------------------------------------------
  // Staging words and push
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_reg <= 64'h0;
      txh_reg <= 32'h0;
    end else if (wr_en) begin
      if (paddr == evq_pkg::OFS_TX_W0) txd_reg[31:0]  <= pwdata;
      if (paddr == evq_pkg::OFS_TX_W1) txd_reg[63:32] <= pwdata;
      if (paddr == evq_pkg::OFS_TX_W2) txh_reg        <= pwdata;
    end
  end

  always_ff @(posedge pclk) begin
    if (tx_push)
      tx_mem[tx_wp_reg] <= {txh_reg[31:30], txh_reg[28:0], txh_reg[29], pwdata[4], pwdata[3:0], txd_reg};
  end

  // Pointers and level, in order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_reg  <= '0;
      tx_rp_reg  <= '0;
      tx_lvl_reg <= 9'h000;
    end else if (tx_clr) begin
      tx_wp_reg  <= '0;
      tx_rp_reg  <= '0;
      tx_lvl_reg <= 9'h000;
    end else begin
      if (tx_push) tx_wp_reg <= tx_wp_reg + AW'(1);
      if (tx_pop)  tx_rp_reg <= tx_rp_reg + AW'(1);
      tx_lvl_reg <= tx_lvl_reg + 9'(tx_push) - 9'(tx_pop);
    end
  end

  // Head of queue to firmware, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fw_avail  <= 1'b0;
      fw_port   <= 2'h0;
      fw_id     <= 29'h0;
      fw_ext    <= 1'b0;
      fw_remote <= 1'b0;
      fw_len    <= 4'h0;
      fw_data   <= 64'h0;
    end else begin
      fw_avail <= !tx_clr && !tx_pop && (tx_lvl_reg != 9'h000) && !fw_avail ? 1'b1 :
                  (tx_pop || tx_clr) ? 1'b0 : fw_avail;
      if (!fw_avail)
        {fw_port, fw_id, fw_ext, fw_remote, fw_len, fw_data} <= tx_mem[tx_rp_reg];
    end
  end

  // ----------------------------------------------------------------
  // Inbound queue
  // ----------------------------------------------------------------
  // Entry packed port, id, type, length, time, payload
  always_ff @(posedge pclk) begin
    if (rx_push)
      rx_mem[rx_wp_reg] <= {ev_port, ev_id, ev_type,
                            (ev_len > 4'h8) ? 4'h8 : ev_len, ts_reg, ev_data};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp_reg  <= '0;
      rx_rp_reg  <= '0;
      rx_lvl_reg <= 9'h000;
    end else if (rx_clr) begin
      rx_wp_reg  <= '0;
      rx_rp_reg  <= '0;
      rx_lvl_reg <= 9'h000;
    end else begin
      if (rx_push) rx_wp_reg <= rx_wp_reg + AW'(1);
      if (rx_pop)  rx_rp_reg <= rx_rp_reg + AW'(1);
      rx_lvl_reg <= rx_lvl_reg + 9'(rx_push) - 9'(rx_pop);
    end
  end

  // Lost events counted while full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lost_reg <= 32'h0;
    end else if (ev_valid && !rx_clr && (rx_lvl_reg >= 9'(evq_pkg::QUEUE_MAX))) begin
      lost_reg <= lost_reg + 32'h1;
    end
  end

  // Bus state tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bus_state_reg <= evq_pkg::BUS_ERROR_ACTIVE;
    else          bus_state_reg <= bus_state_in;
  end

  // Pop window; empty queue yields empty event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_win_reg <= '0;
    end else if (wr_en && (paddr == evq_pkg::OFS_RX_POP)) begin
      if (rx_lvl_reg != 9'h000) begin
        rx_win_reg <= rx_mem[rx_rp_reg];
      end else begin
        rx_win_reg <= '0;
        rx_win_reg[evq_pkg::TYPE_LSB +: 5] <= evq_pkg::EMPTY_EVENT_CLASS;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event filter on each popped entry; batch restarts on cfg write
  // cfg: b1:0 port (0 any,1,2), b2 class exclude, b3 id exclude,
  //      b4 id0 valid, b5 id1 valid, b31:16 class set by code-16
  // ----------------------------------------------------------------
  logic [EW-1:0] cand;
  logic          port_ok, class_ok, id_ok, id_hit;
  logic [4:0]    c_type;

  always_comb begin
    cand     = (rx_lvl_reg != 9'h000) ? rx_mem[rx_rp_reg] : '0;
    if (rx_lvl_reg == 9'h000) cand[evq_pkg::TYPE_LSB +: 5] = evq_pkg::EMPTY_EVENT_CLASS;
    c_type   = cand[evq_pkg::TYPE_LSB +: 5];
    port_ok  = (flt_cfg_reg[1:0] == 2'h0) ||
               (flt_cfg_reg[1:0] == cand[evq_pkg::PORT_LSB +: 2]);
    class_ok = flt_cfg_reg[16 + 32'(c_type[3:0])] ^ flt_cfg_reg[2];
    id_hit   = (flt_cfg_reg[4] && (flt_id0_reg == cand[evq_pkg::ID_LSB +: 29])) ||
               (flt_cfg_reg[5] && (flt_id1_reg == cand[evq_pkg::ID_LSB +: 29]));
    id_ok    = id_hit ^ flt_cfg_reg[3];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_cfg_reg  <= 32'h0;
      flt_id0_reg  <= 29'h0;
      flt_id1_reg  <= 29'h0;
      flt_cnt_reg  <= 8'h00;
      flt_type_reg <= 5'h00;
      flt_idm_reg  <= 29'h0;
    end else if (wr_en && (paddr == evq_pkg::OFS_FLT_CFG)) begin
      flt_cfg_reg <= pwdata;
      flt_cnt_reg <= 8'h00;
    end else if (wr_en && (paddr == evq_pkg::OFS_FLT_ID0)) begin
      flt_id0_reg <= pwdata[28:0];
    end else if (wr_en && (paddr == evq_pkg::OFS_FLT_ID1)) begin
      flt_id1_reg <= pwdata[28:0];
    end else if (wr_en && (paddr == evq_pkg::OFS_RX_POP) && port_ok && class_ok && id_ok) begin
      flt_cnt_reg  <= flt_cnt_reg + 8'h01;
      flt_type_reg <= c_type;
      flt_idm_reg  <= cand[evq_pkg::ID_LSB +: 29];
    end
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait states, unmapped reads zero with error
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= evq_pkg::UNMAPPED_RD;
      if (psel && !penable) begin
        case (paddr)
          evq_pkg::OFS_CTRL:    prdata <= 32'h0;
          evq_pkg::OFS_STATUS:  prdata <= {13'h0, bus_state_reg, 7'h0, rx_lvl_reg};
          evq_pkg::OFS_LOST:    prdata <= lost_reg;
          evq_pkg::OFS_TX_W0:   prdata <= txd_reg[31:0];
          evq_pkg::OFS_TX_W1:   prdata <= txd_reg[63:32];
          evq_pkg::OFS_TX_W2:   prdata <= txh_reg;
          evq_pkg::OFS_TX_PUSH: prdata <= {23'h0, tx_lvl_reg};
          evq_pkg::OFS_RX_POP:  prdata <= {23'h0, rx_lvl_reg};
          evq_pkg::OFS_RX_W0:   prdata <= rx_win_reg[31:0];
          evq_pkg::OFS_RX_W1:   prdata <= rx_win_reg[63:32];
          evq_pkg::OFS_RX_W2:   prdata <= rx_win_reg[evq_pkg::TS_LSB +: 32];
          evq_pkg::OFS_RX_W3:   prdata <= {rx_win_reg[evq_pkg::PORT_LSB +: 2], 1'b0,
                                           rx_win_reg[evq_pkg::ID_LSB +: 29]};
          evq_pkg::OFS_RX_W4:   prdata <= {20'h0, rx_win_reg[evq_pkg::LEN_LSB +: 4], 3'h0,
                                           rx_win_reg[evq_pkg::TYPE_LSB +: 5]};
          evq_pkg::OFS_FLT_CFG: prdata <= flt_cfg_reg;
          evq_pkg::OFS_FLT_ID0: prdata <= {3'h0, flt_id0_reg};
          evq_pkg::OFS_FLT_ID1: prdata <= {3'h0, flt_id1_reg};
          evq_pkg::OFS_FLT_RES: prdata <= {flt_cnt_reg, 3'h0, flt_type_reg, 16'h0} | 32'(flt_idm_reg[15:0]);
          default: begin
            prdata  <= evq_pkg::UNMAPPED_RD;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // can_event_fifo_interface

// *** hw/evq_pkg.sv ***
// Constants for the CAN event queue block: register map, event codes,
// entry layout and reset values.
// Assumes an APB master on the host side and a link-side event source.
// Notes on behaviour
// - Receive frame codes 17, 18, 25, 28
// - Transmit confirm codes 19, 24, 26, 27
// - Codes 16 empty, 21 bus state, 31 error
// - Received data length reported 0 to 8
// - Events timestamped by microsecond counter
// - Payload travels as one 8-byte field
// - Empty read returns empty event code
// - Receive queue 255 deep, overflow counted
// - Lost count and bus state readable
// - Transmit queue 255 deep, overflow dropped
// - Transmit fill level readable
// - Receive fill level readable
// - Transmit clear on value 1 only
// - Receive clear empties queue and level
// - Filter scans batch, last match wins, counts
// - Filter port any, 1 or 2
// - Filter class set, include or exclude
// - Filter identifier list, include or exclude
// - Filter outputs selected entry and count
// - Entry order port, id, type, length, time, payload
// - Firmware drains transmit queue onto bus
package evq_pkg;

  // ----------------------------------------------------------------
  // Event codes
  // ----------------------------------------------------------------
  localparam logic [4:0] EMPTY_EVENT_CLASS      = 5'h10;
  localparam logic [4:0] STD_DATA_CLASS         = 5'h11;
  localparam logic [4:0] STD_REMOTE_CLASS       = 5'h12;
  localparam logic [4:0] STD_DATA_CONFIRM       = 5'h13;
  localparam logic [4:0] BUS_STATE_CHANGE_CLASS = 5'h15;
  localparam logic [4:0] STD_REMOTE_CONFIRM     = 5'h18;
  localparam logic [4:0] EXT_DATA_CLASS         = 5'h19;
  localparam logic [4:0] EXT_DATA_CONFIRM       = 5'h1A;
  localparam logic [4:0] EXT_REMOTE_CONFIRM     = 5'h1B;
  localparam logic [4:0] EXT_REMOTE_CLASS       = 5'h1C;
  localparam logic [4:0] ERROR_FRAME_CLASS      = 5'h1F;

  // ----------------------------------------------------------------
  // Bus state codes
  // ----------------------------------------------------------------
  localparam logic [2:0] BUS_ERROR_ACTIVE  = 3'h3;
  localparam logic [2:0] BUS_ERROR_PASSIVE = 3'h4;
  localparam logic [2:0] BUS_OFF           = 3'h5;

  // ----------------------------------------------------------------
  // Entry layout: port, id, type, length, timestamp, payload
  // ----------------------------------------------------------------
  localparam int ENTRY_W  = 2 + 29 + 5 + 4 + 32 + 64;
  localparam int PAY_LSB  = 0;
  localparam int TS_LSB   = 64;
  localparam int LEN_LSB  = 96;
  localparam int TYPE_LSB = 100;
  localparam int ID_LSB   = 105;
  localparam int PORT_LSB = 134;
  localparam int QUEUE_MAX = 255;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 10_000_000;
  localparam int TS_TICK_NS  = 1000;
  localparam int TS_TICK_CYC = (TS_TICK_NS * (CLK_HZ / 1_000_000)) / 1000;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00; // W: b0 tx clear, b1 rx clear
  localparam logic [7:0] OFS_STATUS   = 8'h04; // R: rx lvl b8:0, bus state b18:16
  localparam logic [7:0] OFS_LOST     = 8'h08; // R: lost event count
  localparam logic [7:0] OFS_TX_W0    = 8'h0C; // payload low
  localparam logic [7:0] OFS_TX_W1    = 8'h10; // payload high
  localparam logic [7:0] OFS_TX_W2    = 8'h14; // id[28:0], ext b29, port b31:30
  localparam logic [7:0] OFS_TX_PUSH  = 8'h18; // W: len[3:0], b4 remote; pushes
  localparam logic [7:0] OFS_RX_POP   = 8'h1C; // W: pop one entry into window
  localparam logic [7:0] OFS_RX_W0    = 8'h20; // payload low
  localparam logic [7:0] OFS_RX_W1    = 8'h24; // payload high
  localparam logic [7:0] OFS_RX_W2    = 8'h28; // timestamp
  localparam logic [7:0] OFS_RX_W3    = 8'h2C; // id[28:0], port b31:30
  localparam logic [7:0] OFS_RX_W4    = 8'h30; // type[4:0], len[11:8]
  localparam logic [7:0] OFS_FLT_CFG  = 8'h34; // filter config
  localparam logic [7:0] OFS_FLT_ID0  = 8'h38; // filter id 0
  localparam logic [7:0] OFS_FLT_ID1  = 8'h3C; // filter id 1
  localparam logic [7:0] OFS_FLT_RES  = 8'h40; // R: match count, type, id
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

endpackage

// *** sim/can_event_fifo_interface_asserts.sv ***
// Port checker for the CAN event queue block, bound at the foot.
// Assumes one clock pclk and async reset presetn, active low.
`timescale 1ns/1ps
module can_event_fifo_interface_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  bus_state_in,
  input wire logic        fw_take,
  input wire logic        fw_avail,
  input wire logic [63:0] fw_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus phases
  sequence s_setup; psel && !penable; endsequence
  sequence s_ctrl_wr; psel && penable && pwrite && paddr == evq_pkg::OFS_CTRL; endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_ready_once; pready |=> !pready; endproperty
  property p_err_ack; pslverr |-> pready; endproperty
  property p_tx_clear; s_ctrl_wr ##0 pwdata[0] |=> !fw_avail; endproperty
  property p_zero_keeps; s_ctrl_wr ##0 (!pwdata[0] && fw_avail && !fw_take) |=> fw_avail; endproperty
  property p_push_shows;
    psel && penable && pwrite && pready && paddr == evq_pkg::OFS_TX_PUSH && !fw_avail |=> ##[0:2] fw_avail;
  endproperty
  property p_head_hold;
    fw_avail && !fw_take && !(psel && pwrite && paddr == evq_pkg::OFS_CTRL) |=> fw_avail && $stable(fw_data);
  endproperty
  property p_bus_state;
    s_setup ##0 (!pwrite && paddr == evq_pkg::OFS_STATUS && $stable(bus_state_in)
      && bus_state_in == $past(bus_state_in, 2)) |=> prdata[18:16] == $past(bus_state_in);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access cycle");
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  a_err_ack: assert property (p_err_ack) else $error("error without ready");
  a_tx_clear: assert property (p_tx_clear) else $error("outbound clear ignored");
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero clear acted");
  a_push_shows: assert property (p_push_shows) else $error("push not visible");
  a_head_hold: assert property (p_head_hold) else $error("head changed untaken");
  a_bus_state: assert property (p_bus_state) else $error("bus state wrong");
endmodule // can_event_fifo_interface_asserts

bind can_event_fifo_interface can_event_fifo_interface_asserts i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_state_in, .fw_take, .fw_avail, .fw_data);

// *** sim/can_event_fifo_interface_bench.sv ***
// Self-checking bench for the CAN event queue block.
// Assumes the node model feeds events and drains the outbound queue.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module can_event_fifo_interface_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  bus_state_in = 3'h3;
  logic        fw_run = 1'b0;
  logic [31:0] prdata, q, ts_prev, m;
  logic        pready, pslverr, qerr, fw_take, fw_avail, ev_valid, fw_ext, fw_remote;
  logic [1:0]  ev_port, fw_port;
  logic [28:0] ev_id, fw_id;
  logic [4:0]  ev_type;
  logic [3:0]  ev_len, fw_len;
  logic [63:0] ev_data, fw_data;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [4:0]  codes[10] = '{5'h11, 5'h12, 5'h19, 5'h1C, 5'h13, 5'h18, 5'h1A, 5'h1B, 5'h15, 5'h1F};
  logic [31:0] fcfg[2] = '{32'h1104_001A, 32'h8020_0034};
  logic [31:0] fid0[2] = '{32'h105, 32'h102};
  logic [31:0] fres[2] = '{32'h021C_0103, 32'h021B_0107};
  logic [2:0]  bstates[3] = '{3'h3, 3'h4, 3'h5};

  can_event_fifo_interface i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ev_valid, .ev_port, .ev_id, .ev_type, .ev_len, .ev_data, .bus_state_in, .fw_take, .fw_avail,
    .fw_port, .fw_id, .fw_ext, .fw_remote, .fw_len, .fw_data);
  can_event_partner i_nodes (.pclk, .presetn, .fw_run, .fw_avail, .fw_id, .fw_take, .ev_valid, .ev_port, .ev_id,
    .ev_type, .ev_len, .ev_data);

  // 10 MHz clock
  always #50 pclk = ~pclk;
  // Cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out;
    $display("Checks: %0d, mismatches: %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One bus transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    qerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, q & k)
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (bstates[k]) begin
      bus_state_in <= bstates[k];
      repeat (3) @(posedge pclk);
      rd(evq_pkg::OFS_STATUS, 32'h0007_01FF, {13'h0, bstates[k], 16'h0}, "status");
    end
    rd(evq_pkg::OFS_LOST, 32'hFFFF_FFFF, 32'h0, "lost");
    rd(evq_pkg::OFS_TX_PUSH, 32'h1FF, 32'h0, "tx level");
    rd(8'h80, 32'hFFFF_FFFF, evq_pkg::UNMAPPED_RD, "unmapped");
    `CHK("unmapped err", 1'b1, qerr)
    for (int p = 0; p < 2; p++) begin
      wr(evq_pkg::OFS_FLT_ID0, fid0[p]);
      wr(evq_pkg::OFS_FLT_ID1, 32'h107);
      wr(evq_pkg::OFS_FLT_CFG, fcfg[p]);
      for (int i = 0; i < 10; i++) begin
        i_nodes.send(i[0] ? 2'h2 : 2'h1, 29'h100 + i[28:0], codes[i], 4'(i % 9),
                     {32'hA5A5_0000 + i, 32'h5A5A_0000 + i});
        repeat (2 * evq_pkg::TS_TICK_CYC - 2) @(posedge pclk);
      end
      rd(evq_pkg::OFS_RX_POP, 32'h1FF, 32'd10, "rx level");
      for (int i = 0; i < 12; i++) begin
        wr(evq_pkg::OFS_RX_POP, 32'h0);
        if (i < 10) begin
          rd(evq_pkg::OFS_RX_W0, 32'hFFFF_FFFF, 32'h5A5A_0000 + i, "pay lo");
          rd(evq_pkg::OFS_RX_W1, 32'hFFFF_FFFF, 32'hA5A5_0000 + i, "pay hi");
          rd(evq_pkg::OFS_RX_W3, 32'hDFFF_FFFF, {i[0] ? 2'h2 : 2'h1, 30'h100 + i[29:0]}, "port id");
          m = (codes[i] == 5'h11 || codes[i] == 5'h19) ? 32'hF1F : 32'h1F;
          rd(evq_pkg::OFS_RX_W4, m, {20'h0, 4'(i % 9), 3'h0, codes[i]} & m, "type len");
          apb(1'b0, evq_pkg::OFS_RX_W2, 32'h0);
          if (i > 0) `CHK("stamp", 32'h2, q - ts_prev)
          ts_prev = q;
        end else begin
          rd(evq_pkg::OFS_RX_W4, 32'h1F, 32'h10, "empty");
        end
      end
      rd(evq_pkg::OFS_FLT_RES, 32'hFF1F_FFFF, fres[p], "filter");
    end
    for (int i = 0; i < 257; i++) i_nodes.send(2'h1, 29'h200 + i[28:0], 5'h11, 4'h8, 64'h0);
    rd(evq_pkg::OFS_RX_POP, 32'h1FF, 32'd255, "rx full");
    rd(evq_pkg::OFS_LOST, 32'hFFFF_FFFF, 32'd2, "lost");
    wr(evq_pkg::OFS_RX_POP, 32'h0);
    rd(evq_pkg::OFS_RX_W3, 32'h1FFF_FFFF, 32'h200, "head");
    wr(evq_pkg::OFS_CTRL, 32'h2);
    rd(evq_pkg::OFS_RX_POP, 32'h1FF, 32'h0, "rx clr");
    wr(evq_pkg::OFS_RX_POP, 32'h0);
    rd(evq_pkg::OFS_RX_W4, 32'h1F, 32'h10, "clr empty");
    for (int k = 0; k < 3; k++) begin
      wr(evq_pkg::OFS_TX_W0, 32'hC0DE_0000 + k);
      wr(evq_pkg::OFS_TX_W1, 32'h0);
      wr(evq_pkg::OFS_TX_W2, 32'h4000_0010 + k);
      wr(evq_pkg::OFS_TX_PUSH, 32'h8);
    end
    rd(evq_pkg::OFS_TX_PUSH, 32'h1FF, 32'd3, "tx level");
    `CHK("head", {2'h1, 2'h0, 4'h8, 32'hC0DE_0000}, {fw_port, fw_ext, fw_remote, fw_len, fw_data[31:0]})
    fw_run <= 1'b1;
    while (i_nodes.got.size() < 3) @(posedge pclk);
    for (int k = 0; k < 3; k++) `CHK("sent id", 29'h10 + k[28:0], i_nodes.got[k])
    fw_run <= 1'b0;
    rd(evq_pkg::OFS_TX_PUSH, 32'h1FF, 32'h0, "tx drained");
    repeat (256) wr(evq_pkg::OFS_TX_PUSH, 32'h8);
    rd(evq_pkg::OFS_TX_PUSH, 32'h1FF, 32'd255, "tx full");
    wr(evq_pkg::OFS_CTRL, 32'h0);
    rd(evq_pkg::OFS_TX_PUSH, 32'h1FF, 32'd255, "tx keep");
    wr(evq_pkg::OFS_CTRL, 32'h1);
    rd(evq_pkg::OFS_TX_PUSH, 32'h1FF, 32'h0, "tx clr");
    close_out();
  end
endmodule // can_event_fifo_interface_bench

// *** sim/can_event_partner.sv ***
// Model of the CAN nodes and of the firmware draining the outbound queue.
// Assumes the queue block samples its event port on the rising pclk edge.
`timescale 1ns/1ps
module can_event_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fw_run,
  input  wire logic        fw_avail,
  input  wire logic [28:0] fw_id,
  output logic             fw_take,
  output logic             ev_valid,
  output logic      [1:0]  ev_port,
  output logic      [28:0] ev_id,
  output logic      [4:0]  ev_type,
  output logic      [3:0]  ev_len,
  output logic      [63:0] ev_data
);
  logic [28:0] got[$]; // Identifiers in send order
  // Quiet event port at time zero
  initial {ev_valid, ev_port, ev_id, ev_type, ev_len, ev_data} = '0;
  // One event per pulse; fields inverted after so stale values cannot pass
  task automatic send(input logic [1:0] p, input logic [28:0] id, input logic [4:0] t,
                      input logic [3:0] n, input logic [63:0] d);
    @(posedge pclk);
    ev_valid <= 1'b1;
    {ev_port, ev_id, ev_type, ev_len, ev_data} <= {p, id, t, n, d};
    @(posedge pclk);
    ev_valid <= 1'b0;
    {ev_port, ev_id, ev_type, ev_len, ev_data} <= ~{p, id, t, n, d};
  endtask
  // Firmware takes the head, never in two cycles running, and logs it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fw_take <= 1'b0;
    end else begin
      fw_take <= fw_run && fw_avail && !fw_take;
      if (fw_take && fw_avail) got.push_back(fw_id);
    end
  end
endmodule // can_event_partner
